// [shared/pbm_pkg.sv]
package pbm_pkg;

  // ----------------------------------------------------------------
  // Register indexes
  // ----------------------------------------------------------------
  localparam logic [4:0] IDX_CTRL      = 5'h00;
  localparam logic [4:0] IDX_STAT      = 5'h01;
  localparam logic [4:0] IDX_ID_HIGH   = 5'h02;
  localparam logic [4:0] IDX_ID_LOW    = 5'h03;
  localparam logic [4:0] IDX_AN_ADV    = 5'h04;
  localparam logic [4:0] IDX_AN_LPA    = 5'h05;
  localparam logic [4:0] IDX_AN_EXP    = 5'h06;
  localparam logic [4:0] IDX_MODE_CS   = 5'h11;
  localparam logic [4:0] IDX_SPEC_MODE = 5'h12;
  localparam logic [4:0] IDX_SPEC_CS   = 5'h1B;
  localparam logic [4:0] IDX_IRQ_SRC   = 5'h1D;
  localparam logic [4:0] IDX_IRQ_MASK  = 5'h1E;
  localparam logic [4:0] IDX_PHY_SCS   = 5'h1F;

  // ----------------------------------------------------------------
  // Control register fields
  // ----------------------------------------------------------------
  localparam int unsigned CTL_SRST     = 15;
  localparam int unsigned CTL_LOOP     = 14;
  localparam int unsigned CTL_SPEED    = 13;
  localparam int unsigned CTL_ANEG     = 12;
  localparam int unsigned CTL_PDOWN    = 11;
  localparam int unsigned CTL_AN_RST   = 9;
  localparam int unsigned CTL_DUPLEX   = 8;
  localparam int unsigned CTL_COLTEST  = 7;
  localparam logic [15:0] CTL_RW_MASK  = 16'h7980;
  localparam logic [15:0] CTL_KEPT     = 16'h0000;
  localparam logic [15:0] CTL_RESET    = 16'h0000;

  // ----------------------------------------------------------------
  // Status register fields
  // ----------------------------------------------------------------
  localparam int unsigned STA_AN_DONE  = 5;
  localparam int unsigned STA_RFAULT   = 4;
  localparam int unsigned STA_LINK     = 2;
  localparam int unsigned STA_JABBER   = 1;
  localparam logic [15:0] STA_FIXED    = 16'h7809;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_NS       = 40;
  localparam int unsigned SRST_NS      = 1000;
  localparam int unsigned SRST_CYC     = (SRST_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [7:0]  STRAP_WAIT   = 8'h03;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        req;
    logic        write;
    logic [4:0]  index;
    logic [15:0] wdata;
  } pbm_acc_req_t;

  typedef struct packed {
    logic        ack;
    logic        bad_index;
    logic [15:0] rdata;
  } pbm_acc_rsp_t;

  typedef struct packed {
    logic link;
    logic rfault;
    logic jabber;
    logic an_done;
    logic an_speed_100;
    logic an_full;
  } pbm_cond_t;

  typedef struct packed {
    logic loopback;
    logic speed_100;
    logic full_duplex;
    logic aneg_en;
    logic power_down;
    logic col_test;
    logic an_restart;
    logic soft_rst;
  } pbm_mode_t;

endpackage

// [verilog/pbm_sync.sv]
`timescale 1ns/10ps
`default_nettype none

// Two-stage synchroniser; the first stage feeds only the second
module pbm_sync (
  input  wire logic i_clk,
  input  wire logic i_nrst,
  input  wire logic i_d,
  output var  logic o_q
);

  typedef struct packed {
    logic s1;
    logic s2;
  } pbm_sync_st_t;

  pbm_sync_st_t s_q;
  pbm_sync_st_t s_d;

  // Shift chain
  always_comb begin
    s_d.s1 = i_d;
    s_d.s2 = s_q.s1;
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_q = s_q.s2;

endmodule

`default_nettype wire

// [verilog/pbm_latch.sv]
`timescale 1ns/10ps
`default_nettype none

// Latching status bit: latch-high or latch-low, cleared by a read
module pbm_latch #(
  parameter bit LATCH_LOW = 1'b0
) (
  input  wire logic i_clk,
  input  wire logic i_nrst,
  input  wire logic i_live,
  input  wire logic i_clr,
  output var  logic o_val
);

  typedef struct packed {
    logic ev;
  } pbm_latch_st_t;

  pbm_latch_st_t s_q;
  pbm_latch_st_t s_d;
  logic          event_now;

  // Event is the high level, or the low level for latch-low
  assign event_now = LATCH_LOW ? !i_live : i_live;

  // Set wins over the read clear
  always_comb begin
    s_d.ev = event_now | (s_q.ev & !i_clr);
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // Reported value merges held event with live level
  assign o_val = LATCH_LOW ? (i_live & !s_q.ev) : (i_live | s_q.ev);

endmodule

`default_nettype wire

// [verilog/pbm_phy_regs.sv]
`timescale 1ns/10ps
`default_nettype none

module pbm_phy_regs #(
  parameter int unsigned SRST_CYCLES = pbm_pkg::SRST_CYC,
  parameter logic [15:0] OUI_HIGH    = 16'h1234, // Arbitrary value
  parameter logic [5:0]  OUI_LOW     = 6'h2A,    // Arbitrary value
  parameter logic [5:0]  MODEL       = 6'h05,    // Arbitrary value
  parameter logic [3:0]  REVISION    = 4'h1      // Arbitrary value
) (
  input  wire logic                  i_clk,
  input  wire logic                  i_nrst,
  input  wire logic                  i_speed_strap,
  input  wire pbm_pkg::pbm_acc_req_t i_acc,
  input  wire pbm_pkg::pbm_cond_t    i_cond,
  output var  pbm_pkg::pbm_acc_rsp_t o_rsp,
  output var  pbm_pkg::pbm_mode_t    o_mode
);

  // ----------------------------------------------------------------
  // Elaboration check
  // ----------------------------------------------------------------
  if (SRST_CYCLES < 1 || SRST_CYCLES > 256) begin : g_bad_srst
    $error("SRST_CYCLES must lie in 1..256");
  end

  localparam logic [7:0] SRST_LOAD = 8'(SRST_CYCLES - 1);

  typedef enum logic [1:0] {
    ST_INIT,
    ST_RUN,
    ST_SRST
  } pbm_state_e_t;

  typedef struct packed {
    pbm_state_e_t          st;
    logic [7:0]            cnt;
    logic [15:0]           ctrl;
    pbm_pkg::pbm_acc_rsp_t rsp;
    pbm_pkg::pbm_mode_t    mode;
  } pbm_state_t;

  pbm_state_t s_q;
  pbm_state_t s_d;
  logic       rst_n;
  logic       strap_s;
  logic       rd_stat;
  logic       wr_ctrl;
  logic       an_live;
  logic       rf_val;
  logic       link_val;
  logic       jab_val;

  // ----------------------------------------------------------------
  // Decoding helpers
  // ----------------------------------------------------------------
  // Whether an index belongs to the register map
  function automatic logic idx_in_map(input logic [4:0] idx);
    case (idx)
      pbm_pkg::IDX_CTRL, pbm_pkg::IDX_STAT, pbm_pkg::IDX_ID_HIGH,
      pbm_pkg::IDX_ID_LOW, pbm_pkg::IDX_AN_ADV, pbm_pkg::IDX_AN_LPA,
      pbm_pkg::IDX_AN_EXP, pbm_pkg::IDX_MODE_CS, pbm_pkg::IDX_SPEC_MODE,
      pbm_pkg::IDX_SPEC_CS, pbm_pkg::IDX_IRQ_SRC, pbm_pkg::IDX_IRQ_MASK,
      pbm_pkg::IDX_PHY_SCS: idx_in_map = 1'b1;
      default: idx_in_map = 1'b0;
    endcase
  endfunction

  // Default control word, speed and negotiation follow the strap
  function automatic logic [15:0] ctrl_dflt(input logic strap);
    logic [15:0] v;
    v = pbm_pkg::CTL_RESET;
    v[pbm_pkg::CTL_SPEED] = strap;
    v[pbm_pkg::CTL_ANEG]  = strap;
    ctrl_dflt = v;
  endfunction

  // ----------------------------------------------------------------
  // Reset release and strap capture
  // ----------------------------------------------------------------
  pbm_sync u_rst_sync (
    .i_clk  (i_clk),
    .i_nrst (i_nrst),
    .i_d    (1'b1),
    .o_q    (rst_n)
  );

  pbm_sync u_strap_sync (
    .i_clk  (i_clk),
    .i_nrst (rst_n),
    .i_d    (i_speed_strap),
    .o_q    (strap_s)
  );

  // ----------------------------------------------------------------
  // Status latches
  // ----------------------------------------------------------------
  // Reads of the status register clear the held events
  assign rd_stat = i_acc.req && !i_acc.write && i_acc.index == pbm_pkg::IDX_STAT;
  // register reach through the access port only
  assign wr_ctrl = i_acc.req && i_acc.write && i_acc.index == pbm_pkg::IDX_CTRL;
  // completion only counts while negotiating and powered
  assign an_live = i_cond.an_done && s_q.mode.aneg_en && !s_q.mode.power_down;

  pbm_latch #(.LATCH_LOW(1'b0)) u_rfault (
    .i_clk  (i_clk),
    .i_nrst (rst_n),
    .i_live (i_cond.rfault),
    .i_clr  (rd_stat),
    .o_val  (rf_val)
  );

  pbm_latch #(.LATCH_LOW(1'b1)) u_link (
    .i_clk  (i_clk),
    .i_nrst (rst_n),
    .i_live (i_cond.link),
    .i_clr  (rd_stat),
    .o_val  (link_val)
  );

  pbm_latch #(.LATCH_LOW(1'b0)) u_jabber (
    .i_clk  (i_clk),
    .i_nrst (rst_n),
    .i_live (i_cond.jabber),
    .i_clr  (rd_stat),
    .o_val  (jab_val)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  // Sequencing, control writes, mode outputs and read answers
  always_comb begin
    logic [15:0] word;
    word = '0;
    s_d = s_q;
    s_d.rsp.ack = 1'b0;
    s_d.mode.an_restart = 1'b0;
    case (s_q.st)
      ST_INIT: begin
        // strap settles through the synchroniser first
        if (s_q.cnt == 8'h00) begin
          s_d.ctrl = ctrl_dflt(strap_s);
          s_d.st = ST_RUN;
        end else begin
          s_d.cnt = s_q.cnt - 8'h01;
        end
      end
      ST_SRST: begin
        // only kept fields survive the software reset
        if (s_q.cnt == 8'h00) begin
          s_d.ctrl = (s_q.ctrl & pbm_pkg::CTL_KEPT) | (ctrl_dflt(strap_s) & ~pbm_pkg::CTL_KEPT);
          s_d.st = ST_RUN;
        end else begin
          s_d.cnt = s_q.cnt - 8'h01;
        end
      end
      ST_RUN: begin
        if (wr_ctrl) begin
          // reset bit wins; other bits of that write are dropped
          if (i_acc.wdata[pbm_pkg::CTL_SRST]) begin
            s_d.st = ST_SRST;
            s_d.cnt = SRST_LOAD;
          end else begin
            // loopback, speed, negotiation, power-down, duplex, collision test
            s_d.ctrl = i_acc.wdata & pbm_pkg::CTL_RW_MASK;
            // restart is a one-cycle pulse, never stored
            s_d.mode.an_restart = i_acc.wdata[pbm_pkg::CTL_AN_RST];
          end
        end
      end
      default: begin
        s_d.st = ST_INIT;
      end
    endcase
    if (s_q.ctrl[pbm_pkg::CTL_PDOWN] && !s_d.ctrl[pbm_pkg::CTL_PDOWN] && s_d.ctrl[pbm_pkg::CTL_ANEG]) begin
      s_d.mode.an_restart = 1'b1;
    end
    // enabling negotiation while in run starts it as well
    if (!s_q.ctrl[pbm_pkg::CTL_ANEG] && s_d.ctrl[pbm_pkg::CTL_ANEG] && s_q.st == ST_RUN) begin
      s_d.mode.an_restart = 1'b1;
    end
    s_d.mode.loopback = s_d.ctrl[pbm_pkg::CTL_LOOP];
    s_d.mode.aneg_en = s_d.ctrl[pbm_pkg::CTL_ANEG];
    s_d.mode.power_down = s_d.ctrl[pbm_pkg::CTL_PDOWN];
    s_d.mode.col_test = s_d.ctrl[pbm_pkg::CTL_COLTEST];
    s_d.mode.soft_rst = (s_d.st != ST_RUN);
    // manual speed and duplex ignored while negotiating
    if (s_d.ctrl[pbm_pkg::CTL_ANEG]) begin
      s_d.mode.speed_100 = i_cond.an_speed_100;
      s_d.mode.full_duplex = i_cond.an_full;
    end else begin
      s_d.mode.speed_100 = s_d.ctrl[pbm_pkg::CTL_SPEED];
      s_d.mode.full_duplex = s_d.ctrl[pbm_pkg::CTL_DUPLEX];
    end
    // read word by index; mapped but absent registers read zero
    case (i_acc.index)
      pbm_pkg::IDX_CTRL: begin
        word = s_q.ctrl;
        word[pbm_pkg::CTL_SRST] = (s_q.st != ST_RUN);
      end
      pbm_pkg::IDX_STAT: begin
        word = pbm_pkg::STA_FIXED;
        word[pbm_pkg::STA_AN_DONE] = an_live;
        // latched bits report live value once cleared
        word[pbm_pkg::STA_RFAULT] = rf_val;
        word[pbm_pkg::STA_LINK] = link_val;
        word[pbm_pkg::STA_JABBER] = jab_val;
      end
      pbm_pkg::IDX_ID_HIGH: word = OUI_HIGH;
      pbm_pkg::IDX_ID_LOW: word = {OUI_LOW, MODEL, REVISION};
      default: word = '0;
    endcase
    if (i_acc.req) begin
      s_d.rsp.ack = 1'b1;
      s_d.rsp.bad_index = !idx_in_map(i_acc.index);
      s_d.rsp.rdata = i_acc.write ? 16'h0000 : word;
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // Starts in init with outputs quiet and soft reset shown
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '{st: ST_INIT, cnt: pbm_pkg::STRAP_WAIT, ctrl: pbm_pkg::CTL_RESET,
               rsp: '0, mode: 8'h01};
    end else begin
      s_q <= s_d;
    end
  end

  assign o_rsp = s_q.rsp;
  assign o_mode = s_q.mode;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!rst_n);

  chk_srst_self_clear: assert property (
    (wr_ctrl && s_q.st == ST_RUN && i_acc.wdata[15]) |=> o_mode.soft_rst ##[1:300] !o_mode.soft_rst)
    else $error("soft reset did not start or clear");

  chk_srst_defaults: assert property (
    $fell(o_mode.soft_rst) |-> (o_mode.loopback == 1'b0 && o_mode.power_down == 1'b0 && o_mode.aneg_en == strap_s))
    else $error("control not at defaults after reset");

  chk_loopback_write: assert property (
    (wr_ctrl && s_q.st == ST_RUN && !i_acc.wdata[15]) |=>
      (o_mode.loopback == $past(i_acc.wdata[14]) && o_mode.col_test == $past(i_acc.wdata[7])))
    else $error("loopback or collision test not taken");

  chk_manual_ignored: assert property (
    o_mode.aneg_en |-> (o_mode.speed_100 == $past(i_cond.an_speed_100) && o_mode.full_duplex == $past(i_cond.an_full)))
    else $error("manual speed or duplex used while negotiating");

  chk_pd_restart: assert property (
    ($fell(o_mode.power_down) && o_mode.aneg_en) |-> o_mode.an_restart)
    else $error("no restart on leaving power-down");

  chk_restart_pulse: assert property (
    (wr_ctrl && s_q.st == ST_RUN && i_acc.wdata[9] && !i_acc.wdata[15]) |=> o_mode.an_restart ##1 !o_mode.an_restart)
    else $error("restart not a single pulse");

  chk_status_fixed: assert property (
    (rd_stat && !$past(rd_stat)) |=> (o_rsp.ack && o_rsp.rdata[15:11] == 5'h0F && o_rsp.rdata[3] && o_rsp.rdata[0]))
    else $error("fixed status bits wrong");

  chk_an_done: assert property (
    rd_stat |=> o_rsp.rdata[5] == $past(i_cond.an_done && o_mode.aneg_en && !o_mode.power_down))
    else $error("negotiation complete bit wrong");

  chk_jabber_hold: assert property (
    (i_cond.jabber ##1 !rd_stat) |-> (jab_val ##1 jab_val))
    else $error("jabber event not held");

  chk_link_low: assert property (
    (!i_cond.link ##1 rd_stat) |=> !o_rsp.rdata[2])
    else $error("link loss not reported");

  chk_id_words: assert property (
    (i_acc.req && !i_acc.write && i_acc.index == pbm_pkg::IDX_ID_LOW) |=> o_rsp.rdata == {OUI_LOW, MODEL, REVISION})
    else $error("identifier low word wrong");

  chk_unmapped_zero: assert property (
    (i_acc.req && !i_acc.write && !idx_in_map(i_acc.index)) |=> (o_rsp.bad_index && o_rsp.rdata == 16'h0000))
    else $error("unmapped index not flagged");

  chk_ack_next: assert property (
    i_acc.req |=> o_rsp.ack)
    else $error("access not answered next cycle");

  chk_rfault_hold: assert property (
    (i_cond.rfault ##1 !rd_stat) |-> (rf_val ##1 rf_val))
    else $error("remote fault event not held");

  chk_id_high: assert property (
    (i_acc.req && !i_acc.write && i_acc.index == pbm_pkg::IDX_ID_HIGH) |=> o_rsp.rdata == OUI_HIGH)
    else $error("identifier high word wrong");

  chk_restart_reads_zero: assert property (
    (i_acc.req && !i_acc.write && i_acc.index == pbm_pkg::IDX_CTRL) |=> !o_rsp.rdata[pbm_pkg::CTL_AN_RST])
    else $error("restart bit read back set");

  chk_srst_readback: assert property (
    (i_acc.req && !i_acc.write && i_acc.index == pbm_pkg::IDX_CTRL && o_mode.soft_rst)
      |=> o_rsp.rdata[pbm_pkg::CTL_SRST])
    else $error("reset bit not shown during reset");

  cov_soft_reset: cover property ($rose(o_mode.soft_rst) ##[1:300] !o_mode.soft_rst);
  cov_restart:    cover property (o_mode.an_restart);
  cov_jab_read:   cover property (i_cond.jabber ##1 rd_stat);
  cov_loopback:   cover property ($rose(o_mode.loopback));
  cov_pd_exit:    cover property ($fell(o_mode.power_down) && o_mode.aneg_en);

endmodule

`default_nettype wire

// [dv/pbm_mac_model.sv]
`timescale 1ns/10ps
`default_nettype none

// Access side of the on-chip MAC: turns bench commands into one request per cycle
module pbm_mac_model (
  input  wire logic                  i_clk,
  input  wire logic                  i_go,
  input  wire logic                  i_write,
  input  wire logic [4:0]            i_index,
  input  wire logic [15:0]           i_wdata,
  output var  pbm_pkg::pbm_acc_req_t o_acc
);
  initial o_acc = '0;

  always @(posedge i_clk) begin
    o_acc.req <= i_go;
    if (i_go) begin
      o_acc.write <= i_write;
      o_acc.index <= i_index;
      o_acc.wdata <= i_wdata[15] ? 16'h8000 : i_wdata;
    end else begin
      // Idle fields toggle so a stale value never passes for a request
      o_acc.write <= ~o_acc.write;
      o_acc.index <= ~o_acc.index;
      o_acc.wdata <= ~o_acc.wdata;
    end
  end
endmodule

`default_nettype wire

// [dv/phy_basic_management_registers_tb.sv]
`timescale 1ns/10ps
`default_nettype none

module phy_basic_management_registers_tb;
  localparam int SRST = 16;
  logic                  clk;
  logic                  nrst;
  logic                  strap;
  logic                  go;
  logic                  wr;
  logic [4:0]            idx;
  logic [15:0]           wd;
  logic [15:0]           w;
  logic [31:0]           lfsr;
  logic [32:0]           e_cur;
  logic [32:0]           exp_q[$];
  pbm_pkg::pbm_cond_t    cond;
  pbm_pkg::pbm_acc_req_t acc;
  pbm_pkg::pbm_acc_rsp_t rsp;
  pbm_pkg::pbm_mode_t    mode;
  int                    fail_count = 0;
  int                    total_checks = 0;
  int                    pulses = 0;
  int                    p0;
  int                    n;

  pbm_mac_model u_pbm_mac_model (.i_clk(clk), .i_go(go), .i_write(wr), .i_index(idx), .i_wdata(wd), .o_acc(acc));
  pbm_phy_regs #(.SRST_CYCLES(SRST)) u_pbm_phy_regs (.i_clk(clk), .i_nrst(nrst), .i_speed_strap(strap),
    .i_acc(acc), .i_cond(cond), .o_rsp(rsp), .o_mode(mode));

  // ----------------------------------------
  // Clock, helpers
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Request held high across calls gives back-to-back accesses
  task automatic acc_op(input logic we, input logic [4:0] i, input logic [15:0] d, input logic [15:0] m,
                        input logic [15:0] e, input logic b);
    exp_q.push_back({b, m, e});
    @(posedge clk);
    go <= 1'b1;
    wr <= we;
    idx <= i;
    wd <= d;
  endtask

  task automatic wr_op(input logic [4:0] i, input logic [15:0] d);
    acc_op(1'b1, i, d, 16'hFFFF, 16'h0000, 1'b0);
  endtask

  task automatic idle_drain();
    @(posedge clk);
    go <= 1'b0;
    for (n = 0; n < 20 && exp_q.size() != 0; n++) @(posedge clk);
    check(16'(exp_q.size()), 16'h0000);
  endtask

  task automatic wait_ready();
    for (n = 0; n < 200 && mode.soft_rst !== 1'b0; n++) @(posedge clk);
    check(16'(mode.soft_rst), 16'h0000);
  endtask

  // ----------------------------------------
  // Response monitor
  // ----------------------------------------
  always @(posedge clk) begin
    if (mode.an_restart === 1'b1) pulses <= pulses + 1;
    if (rsp.ack === 1'b1) begin
      if (exp_q.size() == 0) begin
        check(16'h0001, 16'h0000);
      end else begin
        e_cur = exp_q.pop_front();
        check(16'(rsp.bad_index), 16'(e_cur[32]));
        check(rsp.rdata & e_cur[31:16], e_cur[15:0]);
      end
    end
  end

  // Watchdog cuts a hang short
  initial begin
    #(40 * 6000);
    fail_count++;
    summarize();
  end

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    nrst = 1'b0; strap = 1'b1; go = 1'b0; wr = 1'b0; idx = 5'h00; wd = 16'h0000;
    cond = 6'h27;
    lfsr = 32'hab272233;
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    wait_ready();
    acc_op(1'b0, 5'h00, 16'h0000, 16'hFFFF, 16'h3000, 1'b0);
    acc_op(1'b0, 5'h01, 16'h0000, 16'hFFE9, 16'h7829, 1'b0);
    acc_op(1'b0, 5'h01, 16'h0000, 16'hFFFF, 16'h782D, 1'b0);
    acc_op(1'b0, 5'h02, 16'h0000, 16'hFFFF, 16'h1234, 1'b0);
    acc_op(1'b0, 5'h03, 16'h0000, 16'hFFFF, 16'hA851, 1'b0);
    // every index past the basic set
    for (int i = 4; i < 32; i++)
      acc_op(1'b0, i[4:0], 16'h0000, 16'hFFFF, 16'h0000, !(i < 7 || i == 17 || i == 18 || i == 27 || i >= 29));
    idle_drain();
    for (int k = 0; k < 8; k++) begin
      lfsr = lfsr_next(lfsr);
      w = lfsr[15:0] & 16'h7FFF;
      // Negotiated speed and duplex vary so the override is visible
      cond <= {4'h9, lfsr[17:16]};
      wr_op(5'h00, w);
      acc_op(1'b0, 5'h00, 16'h0000, 16'hFFFF, w & 16'h7980, 1'b0);
      acc_op(1'b0, 5'h01, 16'h0000, 16'h0020, {10'h000, w[12] & ~w[11], 5'h00}, 1'b0);
      idle_drain();
      repeat (2) @(posedge clk);
      check(16'({mode.loopback, mode.speed_100, mode.full_duplex, mode.aneg_en, mode.power_down, mode.col_test}),
            16'({w[14], (w[12] ? lfsr[17] : w[13]), (w[12] ? lfsr[16] : w[8]), w[12], w[11], w[7]}));
    end
    // single restart pulse, bit reads back zero
    wr_op(5'h00, 16'h0000);
    idle_drain();
    p0 = pulses;
    wr_op(5'h00, 16'h0200);
    acc_op(1'b0, 5'h00, 16'h0000, 16'hFFFF, 16'h0000, 1'b0);
    wr_op(5'h02, 16'hFFFF);
    acc_op(1'b0, 5'h02, 16'h0000, 16'hFFFF, 16'h1234, 1'b0);
    idle_drain();
    check(16'(pulses - p0), 16'h0001);
    @(posedge clk) cond <= 6'h1F;
    repeat (3) @(posedge clk);
    cond <= 6'h27;
    repeat (3) @(posedge clk);
    acc_op(1'b0, 5'h01, 16'h0000, 16'h0016, 16'h0012, 1'b0);
    acc_op(1'b0, 5'h01, 16'h0000, 16'h0016, 16'h0004, 1'b0);
    idle_drain();
    wr_op(5'h00, 16'h4180);
    wr_op(5'h00, 16'hC180);
    idle_drain();
    check(16'(mode.soft_rst), 16'h0001);
    acc_op(1'b0, 5'h00, 16'h0000, 16'h8000, 16'h8000, 1'b0);
    idle_drain();
    wait_ready();
    acc_op(1'b0, 5'h00, 16'h0000, 16'hFFFF, 16'h3000, 1'b0);
    idle_drain();
    @(posedge clk);
    nrst <= 1'b0;
    strap <= 1'b0;
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    wait_ready();
    acc_op(1'b0, 5'h00, 16'h0000, 16'hFFFF, 16'h0000, 1'b0);
    idle_drain();
    check(16'({mode.speed_100, mode.aneg_en}), 16'h0000);
    summarize();
  end
endmodule

`default_nettype wire
